// ### core/pipl_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - request on pending or echo; vectors 2/6
// - echo sets on echo while pending and priority
// - echo clears with pending or served vector
// - pending spans instruction; echo until recognised
// - address drive enables vector, sets latch
// - priority out needs in, no request, latch clear
// - set latch blocks lower priority
// - latch clears on init or select code
// - cleared latch passes priority again
// - enable gates level request with stimulus
// - level lines owned only by echo structure
// - data bit four low keeps level request
// - no higher activity: clear store on strobe
// - no-interrupt mode passes priority straight through
// - active request is priority in and pending
// - pending follows store on io clock fall
// - select codes set/clear enable; init clears
module pipl_top #(
  // width of the programmable part of the vector base
  parameter int VEC_BASE_W = 8,
  // base added above the low nibble of every vector
  parameter logic [7:0] VEC_BASE = 8'h00,
  // clear for a board that only passes priority along the chain in the shared build; level line one does not depend on it
  parameter bit GEN_INTERRUPTS = 1'b1,
  // set to request on the two dedicated level lines instead of the shared line
  parameter bit LEVEL_MODE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // processor i/o bus
  input wire pipl_pkg::pipl_iobus_type iobus,
  input wire logic priority_in,
  input wire logic [15:0] data_bus_in,
  output logic [15:0] data_bus_out,
  output logic data_bus_oe_n,
  output pipl_pkg::pipl_req_type req,
  // peripheral stimulus
  input wire logic external_stimulus,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import pipl_pkg::*;

  // state of the interrupt structure; one flip-flop per flag
  // enable and store are the software-visible half, pending and echo belong
  // to the processor handshake, and the disable latch belongs to the chain
  logic interrupt_enable_flag_q;
  logic stimulus_store_flag_q;
  logic pending_flag_q;
  logic echo_request_flag_q;
  logic priority_out_disable_q;
  logic level_one_q;
  logic level_two_q;

  // one-cycle pulses from the synchroniser and the strobe edge finders
  logic stim_rise;
  logic clk_rise;
  logic clk_fall;
  logic pls_rise;
  logic pls_fall;
  logic echo_rise;

  // register bus answer and the registered pin images
  logic ack_q;
  logic [31:0] rdata_q;
  pipl_req_type req_q;
  logic [15:0] dout_q;
  logic oe_n_q;

  // the stimulus is asynchronous; two stages tame metastability before the edge
  pipl_sync u_stim (
    .clk(clk),
    .rstn(rstn),
    .din(external_stimulus),
    .rise(stim_rise)
  );
  // io clock falls time the pending flag
  pipl_edge u_ioclk (
    .clk(clk),
    .rstn(rstn),
    .din(iobus.io_clock),
    .rise(clk_rise),
    .fall(clk_fall)
  );
  // pulse strobe rise is the action point of every bus command
  pipl_edge u_pulse (
    .clk(clk),
    .rstn(rstn),
    .din(iobus.io_pulse_strobe),
    .rise(pls_rise),
    .fall(pls_fall)
  );
  // echo rise arms the echo flag; its fall is of no interest
  pipl_edge u_echo (
    .clk(clk),
    .rstn(rstn),
    .din(iobus.echo),
    .rise(echo_rise),
    .fall()
  );

  // decoded select strobes; pulse rise marks the single action point
  // the pulse strobe stays high for several clocks, so acting on its rise
  // keeps a long strobe from applying one command twice
  function automatic logic fc_hit(input logic [3:0] fc, input logic [3:0] code);
    fc_hit = (fc == code);
  endfunction

  wire addressed_execute_strobe = iobus.device_address_match & iobus.execute_command
      & pls_rise;
  wire enable_set = addressed_execute_strobe & fc_hit(iobus.function_code, PIPL_FC_ENABLE_SET);
  wire enable_clr = addressed_execute_strobe & fc_hit(iobus.function_code, PIPL_FC_ENABLE_CLR);
  wire latch_clear_function_code = fc_hit(iobus.function_code, PIPL_FC_LATCH_CLR);
  wire latch_clr = iobus.controller_initialize
      | (addressed_execute_strobe & latch_clear_function_code);
  wire addressed_io = iobus.device_address_match & pls_rise
      & (iobus.input_command | iobus.output_command | iobus.execute_command);

  // avalon offsets decoded once and shared by the write and read paths
  wire hit_ctrl = (avs_address == PIPL_OFS_CTRL);
  wire hit_stat = (avs_address == PIPL_OFS_STAT);

  // avalon writes land on the edge where waitrequest is low, the same edge
  // at which the master sees the answer; an earlier edge would let a request
  // that is still being held change the flags ahead of its answer
  wire bus_wr = avs_write & ack_q & hit_ctrl;
  wire sw_interrupt_enable_flag_set = bus_wr & avs_writedata[PIPL_CTRL_INTERRUPT_ENABLE_FLAG];
  wire sw_interrupt_enable_flag_clr = bus_wr & ~avs_writedata[PIPL_CTRL_INTERRUPT_ENABLE_FLAG];
  wire sw_latch_clr = bus_wr & avs_writedata[PIPL_CTRL_PDIS];

  // the chain terms stay combinational up to the output register so that
  // a grant from upstream reaches priority out after one clock; a deeper
  // pipeline would eat into the chain's propagation allowance
  // chain and request terms
  wire active_request = priority_in & pending_flag_q & GEN_INTERRUPTS;
  wire vector_address_drive = active_request & iobus.vector_address_request;
  wire echo_owner = active_request & echo_request_flag_q;
  // a higher system interrupt pulls data bit four low while the vector is asked for
  wire higher_active = iobus.vector_address_request
      & ~data_bus_in[PIPL_HIGHER_BIT];
  // a board without interrupts must still hand the grant straight on
  wire priority_out = GEN_INTERRUPTS
      ? (priority_in & ~active_request & ~priority_out_disable_q)
      : priority_in;
  // the base sits above the low nibble, which carries the per-flag code
  wire [15:0] vec_base = {{(16 - PIPL_BASE_POS - VEC_BASE_W){1'b0}}, VEC_BASE,
      {PIPL_BASE_POS{1'b0}}};
  // the echo vector is offered while the echo flag is set, the pending one otherwise
  wire [15:0] vec_addr = vec_base | (echo_request_flag_q ? PIPL_VEC_ECHO
      : PIPL_VEC_PENDING);
  // store clears on strobe of a served vector; in level mode only if no higher claim
  // the level lines carry no device name, so the clear waits for a quiet bit four
  wire vec_served = LEVEL_MODE ? (pls_rise & (level_one_q | level_two_q) & ~higher_active
      & iobus.vector_address_request)
      : (pls_rise & vector_address_drive & ~echo_request_flag_q);

  // enable flag: hardware select codes and software both steer it
  // a clear from init or software beats a set in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_enable_flag_q <= PIPL_RST_FLAG;
    end else if (iobus.controller_initialize | enable_clr | sw_interrupt_enable_flag_clr) begin
      interrupt_enable_flag_q <= 1'b0;
    end else if (enable_set | sw_interrupt_enable_flag_set) begin
      interrupt_enable_flag_q <= 1'b1;
    end
  end

  // store flag: a fresh stimulus edge wins over the served clear in the same cycle; init wins over the edge
  // losing that edge would drop a request, since the stimulus is seen only once
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stimulus_store_flag_q <= PIPL_RST_FLAG;
    end else if (iobus.controller_initialize) begin
      stimulus_store_flag_q <= 1'b0;
    end else if (stim_rise & interrupt_enable_flag_q) begin
      stimulus_store_flag_q <= 1'b1;
    end else if (vec_served) begin
      stimulus_store_flag_q <= 1'b0;
    end
  end

  // pending flag tracks store on falling io clock; holds across the instruction
  // the io clock is held off during an interrupt instruction, so pending
  // cannot fall before the instruction that serves it has finished
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pending_flag_q <= PIPL_RST_FLAG;
    end else if (clk_fall) begin
      pending_flag_q <= interrupt_enable_flag_q & stimulus_store_flag_q;
    end
  end

  // echo flag: only while pending and holding priority
  // a set beats the served clear; only the pending clear overrides it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      echo_request_flag_q <= PIPL_RST_FLAG;
    end else if (!pending_flag_q) begin
      echo_request_flag_q <= 1'b0;
    end else if (echo_rise & active_request) begin
      echo_request_flag_q <= 1'b1;
    end else if (echo_owner & iobus.vector_address_request & pls_rise) begin
      echo_request_flag_q <= 1'b0;
    end
  end

  // disable latch: set by address drive, held through the subroutine
  // a vector drive in the same cycle as a clear keeps the latch set, so a
  // late clear cannot reopen the chain during a fresh acknowledge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      priority_out_disable_q <= PIPL_RST_FLAG;
    end else if (vector_address_drive) begin
      priority_out_disable_q <= 1'b1;
    end else if (latch_clr | sw_latch_clr) begin
      priority_out_disable_q <= 1'b0;
    end
  end

  // level lines: line one from the stimulus store, line two from the echo
  // both lines are driven only here; no other requester may share them
  // in the shared build both lines stay low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_one_q <= 1'b0;
      level_two_q <= 1'b0;
    end else if (LEVEL_MODE) begin
      level_one_q <= interrupt_enable_flag_q & stimulus_store_flag_q;
      level_two_q <= echo_request_flag_q;
    end
  end

  // request and chain pins; one cycle of latency is far below the chain budget
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_q <= '0;
    end else begin
      req_q.shared_vectored_request_line <= ~LEVEL_MODE & active_request;
      req_q.level_one_request_line <= level_one_q;
      req_q.level_two_request_line <= level_two_q;
      req_q.priority_out <= priority_out;
      req_q.vector_address_drive <= vector_address_drive & ~LEVEL_MODE;
    end
  end

  // vector word and its driver enable, which is low while the block drives
  // the word is loaded every cycle; only the enable decides when it is seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout_q <= 16'h0000;
      oe_n_q <= 1'b1;
    end else begin
      dout_q <= vec_addr;
      oe_n_q <= ~(vector_address_drive & ~LEVEL_MODE);
    end
  end

  // control word: enable in bit 0, disable latch in bit 1
  wire [31:0] ctrl_word = {30'h0, priority_out_disable_q, interrupt_enable_flag_q};
  // status word; reading it only samples and never clears a flag
  wire [31:0] stat_word = {27'h0, echo_request_flag_q, pending_flag_q, stimulus_store_flag_q,
      addressed_io, active_request};
  // unmapped offsets read as zero so software can probe them safely
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word
      : hit_stat ? stat_word
      : 32'h0000_0000;

  // avalon slave: waitrequest drops for one cycle per access; the toggle
  // forces one idle edge between two back-to-back requests
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // read word captured every cycle, so it stands at the edge of the answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  // ports are the flip-flops themselves; only waitrequest passes through an inverter after ack_q
  assign req = req_q;
  assign data_bus_out = dout_q;
  assign data_bus_oe_n = oe_n_q;
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = ~ack_q;
endmodule // pipl_top

// ### core/pipl_pkg.sv
package pipl_pkg;
  // vector base addresses for the shared request line
  localparam logic [15:0] PIPL_VEC_PENDING = 16'h0002;
  localparam logic [15:0] PIPL_VEC_ECHO = 16'h0006;
  // offset of the programmable base field (low nibble stays the base code)
  localparam int PIPL_BASE_POS = 4;
  // bit of the data bus pulled low by higher system interrupts
  localparam int PIPL_HIGHER_BIT = 4;
  localparam int PIPL_FC_W = 4;
  // function codes of the addressed select command
  localparam logic [3:0] PIPL_FC_ENABLE_SET = 4'h1;
  localparam logic [3:0] PIPL_FC_ENABLE_CLR = 4'h2;
  localparam logic [3:0] PIPL_FC_LATCH_CLR = 4'h3;
  // reset values
  localparam logic PIPL_RST_FLAG = 1'b0;
  // register map (Avalon word addresses as byte offsets)
  localparam logic [3:0] PIPL_OFS_CTRL = 4'h0;
  localparam logic [3:0] PIPL_OFS_STAT = 4'h4;
  localparam int PIPL_CTRL_INTERRUPT_ENABLE_FLAG = 0;
  localparam int PIPL_CTRL_PDIS = 1;

  // processor i/o bus strobes
  typedef struct packed {
    logic io_clock;
    logic io_pulse_strobe;
    logic vector_address_request;
    logic echo;
    logic execute_command;
    logic input_command;
    logic output_command;
    logic device_address_match;
    logic controller_initialize;
    logic [3:0] function_code;
  } pipl_iobus_type;

  // request and chain outputs, active high inside the block
  typedef struct packed {
    logic shared_vectored_request_line;
    logic level_one_request_line;
    logic level_two_request_line;
    logic priority_out;
    logic vector_address_drive;
  } pipl_req_type;
endpackage

// ### core/pipl_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser with a rising-edge pulse after the second stage
module pipl_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // signal
  input wire logic din,
  output logic rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q & ~s3_q;
endmodule // pipl_sync

// ### core/pipl_edge.sv
`timescale 1ns/1ps
// edge finder on an already synchronous strobe
module pipl_edge (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // strobe
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic prev_q;

  // previous value to find edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= din;
    end
  end

  assign rise = din & ~prev_q;
  assign fall = ~din & prev_q;
endmodule // pipl_edge

// ### tb/pipl_props.sv
`timescale 1ns/1ps
// pin-level checks; expects the shared-line build
module pipl_props import pipl_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // processor side
  input wire pipl_pkg::pipl_iobus_type iobus,
  input wire logic priority_in,
  input wire logic [15:0] data_bus_out,
  input wire logic data_bus_oe_n,
  input wire pipl_pkg::pipl_req_type req,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // an answer stands one cycle only
  sequence ack_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // outputs are registered, so causes are looked up one edge back
  prio_pass_a: assert property (req.priority_out |-> $past(priority_in))
    else $error("priority out without priority in");
  req_blocks_a: assert property (req.shared_vectored_request_line |-> !req.priority_out)
    else $error("priority passed during request");
  req_cause_a: assert property (req.shared_vectored_request_line |-> $past(priority_in))
    else $error("request without priority");
  vec_code_a: assert property (!data_bus_oe_n |-> data_bus_out[3:0] inside {4'h2, 4'h6})
    else $error("bad vector code");
  drive_cause_a: assert property (req.vector_address_drive |->
    $past(iobus.vector_address_request) || $past(iobus.vector_address_request, 2))
    else $error("vector drive without address request");
  drive_blocks_a: assert property (req.vector_address_drive |=> !req.priority_out)
    else $error("priority passed after vector drive");
  level_idle_a: assert property (!req.level_one_request_line && !req.level_two_request_line)
    else $error("level line driven in shared mode");
  bus_answer_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write) ##0 ack_s)
    else $error("bad bus answer");
endmodule // pipl_props
bind pipl_top pipl_props u_props (.clk, .rstn, .iobus, .priority_in, .data_bus_out,
  .data_bus_oe_n, .req, .avs_read, .avs_write, .avs_waitrequest);

// ### tb/pipl_cpu_model.sv
`timescale 1ns/1ps
// processor stand-in: free running i/o clock and the pulled-up data bus
module pipl_cpu_model #(
  parameter int PROCESSOR_IO_CLOCK_HALF = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus
  input wire logic addr_req,
  input wire logic higher,
  output logic io_clock,
  output logic [15:0] data_bus
);
  logic [7:0] cnt_q;
  // the i/o clock runs free, so pending may update at any fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      io_clock <= 1'b0;
    end else if (cnt_q == 8'(PROCESSOR_IO_CLOCK_HALF - 1)) begin
      cnt_q <= 8'h00;
      io_clock <= !io_clock;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // released lines read high; a higher interrupt pulls bit four low
  assign data_bus = (addr_req && higher) ? 16'hffef : 16'hffff;
endmodule // pipl_cpu_model

// ### tb/pipl_test.sv
`timescale 1ns/1ps
module pipl_test;
  import pipl_pkg::*;
  logic clk, rstn, pin, stim, rd, wr, ioclk, oen, wreq;
  logic [3:0] adr;
  logic [31:0] wd, rdat, q;
  logic [15:0] dbi, dbo;
  pipl_iobus_type io, iob, s;
  pipl_req_type req, req_pass;
  int failures, n_compared, i;
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  // the model owns the i/o clock
  always_comb begin
    iob = io;
    iob.io_clock = ioclk;
  end
  pipl_top dut (.clk, .rstn, .iobus(iob), .priority_in(pin), .data_bus_in(dbi),
    .data_bus_out(dbo), .data_bus_oe_n(oen), .req, .external_stimulus(stim),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wreq));
  pipl_cpu_model cpu (.clk, .rstn, .addr_req(io.vector_address_request), .higher(1'b0),
    .io_clock(ioclk), .data_bus(dbi));
  // a board that raises no interrupts only hands the grant along
  pipl_top #(.GEN_INTERRUPTS(1'b0)) u_pass (.clk, .rstn, .iobus(iob), .priority_in(pin),
    .data_bus_in(dbi), .data_bus_out(), .data_bus_oe_n(), .req(req_pass),
    .external_stimulus(stim), .avs_address(adr), .avs_read(1'b0), .avs_write(1'b0),
    .avs_writedata(wd), .avs_readdata(), .avs_waitrequest());
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  // holds the request until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task strobe(input pipl_iobus_type t);
    io <= t;
    repeat (2) @(posedge clk);
    io <= '0;
    repeat (2) @(posedge clk);
  endtask
  task sel(input logic [3:0] fc);
    s = '0;
    s.device_address_match = 1'b1;
    s.execute_command = 1'b1;
    s.io_pulse_strobe = 1'b1;
    s.function_code = fc;
    strobe(s);
  endtask
  // vector request, then the pulse while the vector is driven
  task vec;
    io.vector_address_request <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 20 && oen !== 1'b0; i++) @(posedge clk);
    chk(32'(oen), 32'h0);
    q = 32'(dbo);
    io.io_pulse_strobe <= 1'b1;
    repeat (2) @(posedge clk);
    io <= '0;
    repeat (2) @(posedge clk);
  endtask
  task t_enable;
    sel(PIPL_FC_ENABLE_CLR);
    bus(1'b0, PIPL_OFS_CTRL, 32'h0);
    chk(32'(q[0]), 32'h0);
    sel(PIPL_FC_ENABLE_SET);
    bus(1'b0, PIPL_OFS_CTRL, 32'h0);
    chk(32'(q[0]), 32'h1);
    bus(1'b1, PIPL_OFS_CTRL, 32'h0);
    bus(1'b0, PIPL_OFS_CTRL, 32'h0);
    chk(32'(q[0]), 32'h0);
    bus(1'b1, PIPL_OFS_CTRL, 32'h1);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
  endtask
  task t_irq;
    chk(32'(req.priority_out), 32'h1);
    stim <= 1'b1;
    for (i = 0; i < 40 && req.shared_vectored_request_line !== 1'b1; i++) @(posedge clk);
    chk(32'(req.shared_vectored_request_line), 32'h1);
    chk(32'(req.priority_out), 32'h0);
    s = '0;
    s.echo = 1'b1;
    strobe(s);
    bus(1'b0, PIPL_OFS_STAT, 32'h0);
    chk(32'(q[4]), 32'h1);
    vec();
    chk(q, 32'(PIPL_VEC_ECHO));
    bus(1'b0, PIPL_OFS_STAT, 32'h0);
    chk(32'(q[4]), 32'h0);
    chk(32'(q[3]), 32'h1);
    vec();
    chk(q, 32'(PIPL_VEC_PENDING));
    for (i = 0; i < 40 && req.shared_vectored_request_line !== 1'b0; i++) @(posedge clk);
    chk(32'(req.shared_vectored_request_line), 32'h0);
    repeat (4) @(posedge clk);
    chk(32'(req.priority_out), 32'h0);
    sel(PIPL_FC_LATCH_CLR);
    chk(32'(req.priority_out), 32'h1);
    stim <= 1'b0;
  endtask
  // upstream grant withdrawn and restored, with and without interrupts built in
  task t_chain;
    pin <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(req.priority_out), 32'h0);
    chk(32'(req_pass.priority_out), 32'h0);
    pin <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(req.priority_out), 32'h1);
    chk(32'(req_pass.priority_out), 32'h1);
  endtask
  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    results();
  end
  // main sequence
  initial begin
    failures = 0;
    n_compared = 0;
    rstn = 1'b0;
    pin = 1'b1;
    stim = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wd = 32'h0;
    io = '0;
    repeat (6) @(posedge clk);
    chk(32'(req), 32'h0);
    chk(32'({oen, wreq}), 32'h3);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_enable();
    t_irq();
    t_chain();
    results();
  end
endmodule // pipl_test
